// file: rtl/opp_pkg.sv
package opp_pkg;

   // Switch and address widths
   localparam int unsigned SW_W     = 4;
   localparam int unsigned CHAN_W   = 3;
   localparam int unsigned DEV_W    = 8;
   localparam int unsigned NBTN     = 4;

   // Channel position that carries no channel
   localparam logic [CHAN_W-1:0] CHAN_UNUSED = 3'h6;

   // Register bus geometry
   localparam int unsigned ADDR_W   = 4;
   localparam int unsigned DATA_W   = 16;

   // Register offsets
   localparam logic [ADDR_W-1:0] REG_EVENT  = 4'h0;
   localparam logic [ADDR_W-1:0] REG_MASK   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_SWITCH = 4'h2;
   localparam logic [ADDR_W-1:0] REG_STATE  = 4'h3;

   // Event bit positions, shared by the event and mask registers
   localparam int unsigned EV_EMERG    = 0;
   localparam int unsigned EV_LOAD_GO  = 1;
   localparam int unsigned EV_LOAD_END = 2;
   localparam int unsigned EV_BAD_CHAN = 3;
   localparam int unsigned EV_FAULT    = 4;
   localparam int unsigned EV_READY    = 5;
   localparam int unsigned NEV         = 6;

   // Field positions in the state register
   localparam int unsigned ST_PWR      = 0;
   localparam int unsigned ST_MASTER   = 4;
   localparam int unsigned ST_PFAIL    = 5;
   localparam int unsigned ST_LOADING  = 6;
   localparam int unsigned ST_LOAD_LMP = 7;
   localparam int unsigned ST_IDLE     = 8;
   localparam int unsigned ST_THERM    = 9;

   // Field positions in the switch register
   localparam int unsigned SWR_LO      = 0;
   localparam int unsigned SWR_HI      = 4;
   localparam int unsigned SWR_CHAN    = 8;

   // Button bit positions on the edge detector
   localparam int unsigned BTN_MASTER  = 0;
   localparam int unsigned BTN_LOAD    = 1;
   localparam int unsigned BTN_PON     = 2;
   localparam int unsigned BTN_POFF    = 3;

   // Values after reset
   localparam logic [NEV-1:0]    MASK_RST  = 6'h00;
   localparam logic [NEV-1:0]    EVENT_RST = 6'h00;
   localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;

   // Power sequencing states, one-hot
   typedef enum logic [3:0] {
      pwr_off    = 4'h1,
      pwr_seq_on = 4'h2,
      pwr_ready  = 4'h4,
      pwr_seq_off= 4'h8
   } opp_pwr_e;

endpackage : opp_pkg

// file: rtl/opp_edge.sv
`timescale 1ns/1ps
`default_nettype none

// Rising-edge detector for pushbuttons, one press gives one pulse
module opp_edge #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // Button levels and press pulses
   input  wire logic [W-1:0] level,
   output logic      [W-1:0] press
);

   typedef struct packed {
      logic [W-1:0] prev;
   } opp_edge_s;

   opp_edge_s st;
   opp_edge_s next_st;

   // Remember last level so a held button fires only once
   always_comb begin
      next_st      = st;
      next_st.prev = level;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign press = level & ~st.prev;

endmodule : opp_edge

`default_nettype wire

// file: rtl/opp_panel.sv
// Functional notes
// [RULE1] Each of the three load selectors gives a four-bit value 0 to F.
// [RULE2] The left selector gives a three-bit channel; only 0-5 and 7 count.
// [RULE3] The device number is centre selector high nibble, right low nibble.
// [RULE4] A load press starts program load from the selected channel/device.
// [RULE5] A maintenance power-on request is ignored unless master is on.
// [RULE6] The master button toggles; its lamp is lit while master is on.
// [RULE7] Master off with power up drops AC at once and raises power fail.
// [RULE8] Power ready lights at end of power-on and stays until power goes.
// [RULE9] The idle lamp is lit while the processor runs its idle instruction.
// [RULE10] Holding the idle button lights every panel lamp as a lamp test.
// [RULE11] The thermal alarm lamp follows the processor over-temperature sense.
// [RULE12] Main and supplemental supplies are interlocked and cycle as one.
// [RULE13] Load press lights load and run lamps; load lamp clears on success.
`timescale 1ns/1ps
`default_nettype none

module opp_panel
   import opp_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // Load unit selectors
   input  wire logic [SW_W-1:0]   chan_sel,
   input  wire logic [SW_W-1:0]   dev_hi_sel,
   input  wire logic [SW_W-1:0]   dev_lo_sel,
   // Operator pushbuttons, high while pressed
   input  wire logic              master_btn,
   input  wire logic              load_btn,
   input  wire logic              idle_btn,
   // Maintenance power buttons, high while pressed
   input  wire logic              maint_pon_btn,
   input  wire logic              maint_poff_btn,
   // Power sequencer answers
   input  wire logic              seq_on_done,
   input  wire logic              seq_off_done,
   input  wire logic              main_fault,
   input  wire logic              supp_fault,
   // Power sequencer commands
   output logic                   ac_on,
   output logic                   main_supply_en,
   output logic                   supp_supply_en,
   output logic                   dc_on_cmd,
   output logic                   dc_off_cmd,
   // Processor core status
   input  wire logic              cpu_idle,
   input  wire logic              cpu_running,
   input  wire logic              over_temp,
   input  wire logic              load_done,
   input  wire logic              load_ok,
   input  wire logic              pfail_ack,
   // Processor core requests
   output logic                   ipl_start,
   output logic [CHAN_W-1:0]      ipl_chan,
   output logic [DEV_W-1:0]       ipl_dev,
   output logic                   pfail_flag,
   // Panel lamps
   output logic                   master_lamp,
   output logic                   power_ready_lamp,
   output logic                   idle_lamp,
   output logic                   thermal_alarm_lamp,
   output logic                   load_lamp,
   output logic                   run_lamp,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   // Interrupt to software
   output logic                   irq
);

   typedef struct packed {
      opp_pwr_e          pwr;
      logic              master_on;
      logic              pfail;
      logic              load_lmp;
      logic              loading;
      logic              start;
      logic [CHAN_W-1:0] chan;
      logic [DEV_W-1:0]  dev;
      logic [NEV-1:0]    events;
      logic [NEV-1:0]    mask;
      logic [DATA_W-1:0] rdata;
   } opp_panel_s;

   opp_panel_s st;
   opp_panel_s next_st;

   logic [NBTN-1:0]   btn_lvl;
   logic [NBTN-1:0]   press;
   logic [NEV-1:0]    ev_set;
   logic [NEV-1:0]    ev_clr;
   logic [CHAN_W-1:0] sel_chan;
   logic [DEV_W-1:0]  sel_dev;
   logic              chan_ok;
   logic              powered;
   logic              emerg;
   logic              fault;
   logic              load_go;
   logic              load_bad;
   logic              load_end;
   logic              ready_rise;
   logic              lamp_test;
   logic [DATA_W-1:0] rd_mux;

   // One edge detector serves all momentary buttons but the idle button, which is used as a level
   assign btn_lvl[BTN_MASTER] = master_btn;
   assign btn_lvl[BTN_LOAD]   = load_btn;
   assign btn_lvl[BTN_PON]    = maint_pon_btn;
   assign btn_lvl[BTN_POFF]   = maint_poff_btn;

   opp_edge #(
      .W (NBTN)
   ) u_edge (
      .clk   (clk),
      .rstn  (rstn),
      .level (btn_lvl),
      .press (press)
   );

   // Selector decode; the fourth channel bit is dropped from the channel number
   assign sel_chan = chan_sel[CHAN_W-1:0];                 // [RULE1] [RULE2]
   assign sel_dev  = {dev_hi_sel, dev_lo_sel};             // [RULE1] [RULE3]
   // Position 6 and the upper eight positions select no channel
   assign chan_ok  = !chan_sel[SW_W-1]
                     && (sel_chan != CHAN_UNUSED);         // [RULE2]

   // Power is up in every state but off
   assign powered  = (st.pwr != pwr_off);

   // Master pressed while power is up is the emergency off path
   assign emerg    = press[BTN_MASTER] && st.master_on
                     && powered;                           // [RULE7]

   // A fault in either supply cycles both
   assign fault    = (main_fault || supp_fault) && powered; // [RULE12]

   // Load needs ready power and no load already in flight
   // A load press in the cycle that power drops must not start the core
   assign load_go  = press[BTN_LOAD] && (st.pwr == pwr_ready)
                     && !st.loading && chan_ok
                     && !emerg && !fault;                  // [RULE4]
   assign load_bad = press[BTN_LOAD] && (st.pwr == pwr_ready)
                     && !st.loading && !chan_ok;           // [RULE2]
   assign load_end = st.loading && load_done;

   assign ready_rise = (st.pwr == pwr_seq_on) && seq_on_done
                       && !fault && !emerg;

   // Events gathered for the sticky event register
   always_comb begin
      ev_set              = '0;
      ev_set[EV_EMERG]    = emerg;
      ev_set[EV_LOAD_GO]  = load_go;
      ev_set[EV_LOAD_END] = load_end;
      ev_set[EV_BAD_CHAN] = load_bad;
      ev_set[EV_FAULT]    = fault;
      ev_set[EV_READY]    = ready_rise;
   end

   // Write-one-to-clear on the event register
   assign ev_clr = (reg_wr && (reg_addr == REG_EVENT))
                   ? reg_wdata[NEV-1:0] : '0;

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rd_mux = '0;
      case (reg_addr)
         REG_EVENT: begin
            rd_mux[NEV-1:0] = st.events;
         end
         REG_MASK: begin
            rd_mux[NEV-1:0] = st.mask;
         end
         REG_SWITCH: begin
            rd_mux[SWR_LO +: SW_W]   = dev_lo_sel;
            rd_mux[SWR_HI +: SW_W]   = dev_hi_sel;
            rd_mux[SWR_CHAN +: SW_W] = chan_sel;
         end
         REG_STATE: begin
            rd_mux[ST_PWR +: 4]    = st.pwr;
            rd_mux[ST_MASTER]      = st.master_on;
            rd_mux[ST_PFAIL]       = st.pfail;
            rd_mux[ST_LOADING]     = st.loading;
            rd_mux[ST_LOAD_LMP]    = st.load_lmp;
            rd_mux[ST_IDLE]        = cpu_idle;
            rd_mux[ST_THERM]       = over_temp;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // All state updates in one place
   always_comb begin
      next_st       = st;
      next_st.start = 1'b0;

      // Master toggles on every press, in either direction
      if (press[BTN_MASTER]) begin
         next_st.master_on = !st.master_on;                // [RULE6]
      end

      // Power sequencing
      case (st.pwr)
         pwr_off: begin
            // Maintenance power-on only counts with master on
            if (press[BTN_PON] && st.master_on
                && !press[BTN_MASTER]) begin               // [RULE5]
               next_st.pwr = pwr_seq_on;
            end
         end
         pwr_seq_on: begin
            if (seq_on_done) begin
               next_st.pwr = pwr_ready;                    // [RULE8]
            end
         end
         pwr_ready: begin
            if (press[BTN_POFF]) begin
               next_st.pwr = pwr_seq_off;
            end
         end
         pwr_seq_off: begin
            // Ready stays lit until off sequencing finishes
            if (seq_off_done) begin
               next_st.pwr = pwr_off;                      // [RULE8]
            end
         end
         default: begin
            next_st.pwr = pwr_off;
         end
      endcase

      // Emergency off and supply faults skip the DC off sequence;
      // this overrides whatever the sequencer chose above
      if (emerg || fault) begin
         next_st.pwr = pwr_off;                            // [RULE7] [RULE12]
      end

      // Power fail flag to the core; a new set beats the acknowledge
      if (emerg) begin
         next_st.pfail = 1'b1;                             // [RULE7]
      end else if (pfail_ack) begin
         next_st.pfail = 1'b0;
      end

      // Load request latches the selectors for the core
      if (load_go) begin
         next_st.start   = 1'b1;                           // [RULE4]
         next_st.chan    = sel_chan;                       // [RULE4]
         next_st.dev     = sel_dev;                        // [RULE4]
         next_st.loading = 1'b1;
      end else if (load_end) begin
         next_st.loading = 1'b0;
      end

      // Load lamp lit by the press, cleared on a good finish or when power goes off
      if (load_go) begin
         next_st.load_lmp = 1'b1;                          // [RULE13]
      end else if (load_end && load_ok) begin
         next_st.load_lmp = 1'b0;                          // [RULE13]
      end

      // Losing power abandons any load in flight
      if (next_st.pwr == pwr_off) begin
         next_st.loading  = 1'b0;
         next_st.load_lmp = 1'b0;
      end

      // Sticky events; a set in the same cycle as a clear wins
      next_st.events = (st.events & ~ev_clr) | ev_set;

      if (reg_wr && (reg_addr == REG_MASK)) begin
         next_st.mask = reg_wdata[NEV-1:0];
      end

      // Read data stand only in the cycle after the strobe
      next_st.rdata = reg_rd ? rd_mux : RDATA_RST;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st           <= '0;
         st.pwr       <= pwr_off;
         st.events    <= EVENT_RST;
         st.mask      <= MASK_RST;
         st.rdata     <= RDATA_RST;
      end else begin
         st <= next_st;
      end
   end

   // Supply control; one enable feeds both supplies so they cycle together
   assign ac_on          = powered;
   assign main_supply_en = powered;                        // [RULE12]
   assign supp_supply_en = powered;                        // [RULE12]
   assign dc_on_cmd      = (st.pwr == pwr_seq_on);
   assign dc_off_cmd     = (st.pwr == pwr_seq_off);

   // Core-facing outputs come straight from flip-flops
   assign ipl_start  = st.start;
   assign ipl_chan   = st.chan;
   assign ipl_dev    = st.dev;
   assign pfail_flag = st.pfail;

   // Lamps; the idle button overrides every one of them
   assign lamp_test          = idle_btn;                   // [RULE10]
   assign master_lamp        = st.master_on || lamp_test;  // [RULE6] [RULE10]
   assign power_ready_lamp   = (st.pwr == pwr_ready)
                               || (st.pwr == pwr_seq_off)
                               || lamp_test;               // [RULE8] [RULE10]
   assign idle_lamp          = cpu_idle || lamp_test;      // [RULE9] [RULE10]
   assign thermal_alarm_lamp = over_temp || lamp_test;     // [RULE11] [RULE10]
   assign load_lamp          = st.load_lmp || lamp_test;   // [RULE13] [RULE10]
   // Run lamp shows the load as well, since the core may not report running
   // until the first loaded record is in
   assign run_lamp           = cpu_running || st.load_lmp
                               || lamp_test;               // [RULE13] [RULE10]

   // Register read data and interrupt
   assign reg_rdata = st.rdata;
   assign irq       = |(st.events & st.mask);

endmodule : opp_panel

`default_nettype wire

// file: bench/opp_checker.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level watcher for the operator panel
module opp_checker
   import opp_pkg::*;
(
   // Clock and reset
   input wire logic              clk,
   input wire logic              rstn,
   // Selectors and levels
   input wire logic [SW_W-1:0]   chan_sel,
   input wire logic [SW_W-1:0]   dev_hi_sel,
   input wire logic [SW_W-1:0]   dev_lo_sel,
   input wire logic              idle_btn,
   input wire logic              main_fault,
   input wire logic              supp_fault,
   input wire logic              cpu_idle,
   input wire logic              over_temp,
   input wire logic              load_done,
   input wire logic              load_ok,
   input wire logic              reg_rd,
   // Design outputs
   input wire logic              ac_on,
   input wire logic              main_supply_en,
   input wire logic              supp_supply_en,
   input wire logic              dc_on_cmd,
   input wire logic              ipl_start,
   input wire logic [CHAN_W-1:0] ipl_chan,
   input wire logic [DEV_W-1:0]  ipl_dev,
   input wire logic              pfail_flag,
   input wire logic              master_lamp,
   input wire logic              power_ready_lamp,
   input wire logic              idle_lamp,
   input wire logic              thermal_alarm_lamp,
   input wire logic              load_lamp,
   input wire logic              run_lamp,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              irq
);
   // One clock domain, so clocking and disable are shared
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   a_ipl_pulse: assert property (ipl_start |=> !ipl_start)
      else $error("load start longer than one cycle");
   a_dev_capture: assert property (
      ipl_start |-> ipl_dev == $past({dev_hi_sel, dev_lo_sel}))
      else $error("device number not taken from selectors");
   a_chan_capture: assert property (
      ipl_start |-> ipl_chan == $past(chan_sel[2:0])
      && !$past(chan_sel[3]) && $past(chan_sel) != 4'h6)
      else $error("load started on a bad channel");
   a_pon_gate: assert property (
      !master_lamp && !idle_btn && !ac_on |=> !ac_on)
      else $error("power came up with master off");
   a_supply_lock: assert property (
      main_supply_en == ac_on && supp_supply_en == ac_on)
      else $error("supplies not switched together");
   a_fault_off: assert property (
      ac_on && (main_fault || supp_fault) |=> !ac_on)
      else $error("supply fault did not drop power");
   a_emerg_pfail: assert property (
      $rose(pfail_flag) |-> $fell(ac_on))
      else $error("power fail flag without power drop");
   a_ready_on: assert property (
      $fell(dc_on_cmd) && ac_on |-> power_ready_lamp)
      else $error("ready lamp off after power on");
   a_ready_drop: assert property (
      !ac_on |-> !power_ready_lamp || idle_btn)
      else $error("ready lamp lit without power");
   a_lamp_test: assert property (
      idle_btn |-> master_lamp && power_ready_lamp && idle_lamp
      && thermal_alarm_lamp && load_lamp && run_lamp)
      else $error("lamp test left a lamp dark");
   a_idle_lamp: assert property (
      idle_lamp == (cpu_idle || idle_btn))
      else $error("idle lamp wrong");
   a_therm_lamp: assert property (
      thermal_alarm_lamp == (over_temp || idle_btn))
      else $error("thermal alarm lamp wrong");
   a_load_lamps: assert property (
      ipl_start |-> load_lamp && run_lamp)
      else $error("load and run lamps not lit on start");
   a_load_clear: assert property (
      load_done && load_ok |=> !load_lamp || idle_btn)
      else $error("load lamp kept after good load");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");

   // Main scenarios reached
   c_load: cover property (ipl_start);
   c_emerg: cover property ($rose(pfail_flag));
   c_ready: cover property ($rose(power_ready_lamp));
   c_irq: cover property (irq);
endmodule : opp_checker

bind opp_panel opp_checker u_chk (.clk(clk), .rstn(rstn),
   .chan_sel(chan_sel), .dev_hi_sel(dev_hi_sel), .dev_lo_sel(dev_lo_sel),
   .idle_btn(idle_btn), .main_fault(main_fault), .supp_fault(supp_fault),
   .cpu_idle(cpu_idle), .over_temp(over_temp), .load_done(load_done),
   .load_ok(load_ok), .reg_rd(reg_rd), .ac_on(ac_on),
   .main_supply_en(main_supply_en), .supp_supply_en(supp_supply_en),
   .dc_on_cmd(dc_on_cmd), .ipl_start(ipl_start), .ipl_chan(ipl_chan),
   .ipl_dev(ipl_dev), .pfail_flag(pfail_flag), .master_lamp(master_lamp),
   .power_ready_lamp(power_ready_lamp), .idle_lamp(idle_lamp),
   .thermal_alarm_lamp(thermal_alarm_lamp), .load_lamp(load_lamp),
   .run_lamp(run_lamp), .reg_rdata(reg_rdata), .irq(irq));

`default_nettype wire

// file: bench/opp_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Power sequencer and processor core stand-in
module opp_core_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Behaviour knobs
   input  wire logic [3:0] dly,
   input  wire logic       ok_k,
   // Panel commands
   input  wire logic       dc_on_cmd,
   input  wire logic       dc_off_cmd,
   input  wire logic       ipl_start,
   // Answers
   output logic            seq_on_done,
   output logic            seq_off_done,
   output logic            load_done,
   output logic            load_ok
);
   logic [4:0] on_c, off_c, ld_c;

   // Sequencer answers come dly+1 cycles late, load_done dly+3 after ipl_start; load_ok toggles outside its pulse so a
   // design that samples it at the wrong time sees junk
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {on_c, off_c, ld_c} <= '0;
         {seq_on_done, seq_off_done, load_done, load_ok} <= '0;
      end else begin
         on_c <= dc_on_cmd ? on_c + 5'h01 : 5'h00;
         off_c <= dc_off_cmd ? off_c + 5'h01 : 5'h00;
         seq_on_done <= dc_on_cmd && on_c >= {1'b0, dly};
         seq_off_done <= dc_off_cmd && off_c >= {1'b0, dly};
         if (ipl_start) ld_c <= {1'b0, dly} + 5'h02;
         else if (ld_c != 5'h00) ld_c <= ld_c - 5'h01;
         load_done <= ld_c == 5'h01;
         load_ok <= (ld_c == 5'h01) ? ok_k : ~load_ok;
      end
   end
endmodule : opp_core_model

`default_nettype wire

// file: bench/opp_panel_tb.sv
`timescale 1ns/1ps
`default_nettype none

module opp_panel_tb;
   import opp_pkg::*;
   logic              clk = 1'b0, rstn = 1'b0;
   logic [3:0]        chan_sel = '0, dev_hi_sel = '0, dev_lo_sel = '0;
   logic [NBTN-1:0]   btn = '0;
   logic              idle_btn = 0, main_fault = 0, supp_fault = 0;
   logic              cpu_idle = 0, cpu_running = 0, over_temp = 0;
   logic              pfail_ack = 0, reg_wr = 0, reg_rd = 0, ok_k = 1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic [3:0]        dly = '0;
   wire logic         son, soff, ld_done, ld_ok, ac_on, m_en, s_en, dc_on;
   wire logic         dc_off, ipl_start, pfail, m_lmp, r_lmp, i_lmp;
   wire logic         t_lmp, l_lmp, run_lmp, irq;
   wire logic [2:0]   ipl_chan;
   wire logic [7:0]   ipl_dev;
   wire logic [15:0]  reg_rdata;
   int                miscompares = 0, samples_checked = 0;

   opp_panel dut (.clk(clk), .rstn(rstn), .chan_sel(chan_sel),
      .dev_hi_sel(dev_hi_sel), .dev_lo_sel(dev_lo_sel),
      .master_btn(btn[BTN_MASTER]), .load_btn(btn[BTN_LOAD]),
      .idle_btn(idle_btn), .maint_pon_btn(btn[BTN_PON]),
      .maint_poff_btn(btn[BTN_POFF]), .seq_on_done(son),
      .seq_off_done(soff), .main_fault(main_fault), .supp_fault(supp_fault),
      .ac_on(ac_on), .main_supply_en(m_en), .supp_supply_en(s_en),
      .dc_on_cmd(dc_on), .dc_off_cmd(dc_off), .cpu_idle(cpu_idle),
      .cpu_running(cpu_running), .over_temp(over_temp), .load_done(ld_done),
      .load_ok(ld_ok), .pfail_ack(pfail_ack), .ipl_start(ipl_start),
      .ipl_chan(ipl_chan), .ipl_dev(ipl_dev), .pfail_flag(pfail),
      .master_lamp(m_lmp), .power_ready_lamp(r_lmp), .idle_lamp(i_lmp),
      .thermal_alarm_lamp(t_lmp), .load_lamp(l_lmp), .run_lamp(run_lmp),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

   opp_core_model u_far (.clk(clk), .rstn(rstn), .dly(dly), .ok_k(ok_k),
      .dc_on_cmd(dc_on), .dc_off_cmd(dc_off), .ipl_start(ipl_start),
      .seq_on_done(son), .seq_off_done(soff), .load_done(ld_done),
      .load_ok(ld_ok));

   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   // Verdict and end of run
   task automatic summarize();
      if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One press: up for one cycle, returns in the answer cycle
   task automatic press(int b);
      @(posedge clk) btn[b] <= 1'b1;
      @(posedge clk) btn[b] <= 1'b0;
      #1;
   endtask : press

   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
      #1;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] a, logic [15:0] exp, string what);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      #1 check(what, reg_rdata, exp);
   endtask : rd

   // Bounded wait on ready lamp (w=0) or load done (w=1)
   task automatic wait_on(bit w, logic exp);
      for (int n = 0; n < 60; n++) begin
         @(posedge clk) #1;
         if ((w ? ld_done : r_lmp) === exp) return;
      end
      miscompares++;
      summarize();
   endtask : wait_on

   function automatic logic chan_ok(logic [3:0] c);
      return !c[3] && c != 4'h6;
   endfunction : chan_ok

   // Hang guard
   initial begin
      #1000000;
      miscompares++;
      summarize();
   end

   initial begin
      void'($urandom(18));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd(REG_MASK, 16'h0000, "mask reset");
      rd(REG_EVENT, 16'h0000, "event reset");
      rd(4'hF, 16'h0000, "unmapped");
      wr(REG_STATE, 16'hFFFF);
      rd(REG_STATE, 16'h0001, "state reset");
      press(BTN_PON);
      check("pon gated", ac_on, 0);
      press(BTN_MASTER);
      check("master lamp", m_lmp, 1);
      press(BTN_PON);
      check("power cmds", {ac_on, m_en, s_en, dc_on}, 4'hF);
      wait_on(0, 1);
      rd(REG_EVENT, 16'h0020, "ready event");
      wr(REG_MASK, 16'h0020);
      check("irq", irq, 1);
      wr(REG_EVENT, 16'h0020);
      check("irq clear", irq, 0);
      // Corner channels 6, 7, F first, then random ones
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         chan_sel <= (i < 3) ? 12'h67F >> (8 - 4 * i) : $urandom;
         {dev_hi_sel, dev_lo_sel, dly} <= $urandom;
         ok_k <= i[0];
         wr(REG_EVENT, 16'h003F);
         rd(REG_SWITCH, {4'h0, chan_sel, dev_hi_sel, dev_lo_sel},
            "sw");
         press(BTN_LOAD);
         check("start", ipl_start, chan_ok(chan_sel));
         if (chan_ok(chan_sel)) begin
            check("chan", ipl_chan, chan_sel[2:0]);
            check("dev", ipl_dev, {dev_hi_sel, dev_lo_sel});
            check("lamps", {l_lmp, run_lmp}, 2'b11);
            wait_on(1, 1);
            @(posedge clk) #1 check("load lamp", l_lmp, !ok_k);
            check("irq masked", irq, 0);
            rd(REG_EVENT, 16'h0006, "load events");
         end else rd(REG_EVENT, 16'h0008, "bad chan");
      end
      @(posedge clk) {idle_btn, cpu_idle, over_temp} <= 3'b100;
      #1 check("lamp test",
         {m_lmp, r_lmp, i_lmp, t_lmp, l_lmp, run_lmp}, 6'h3F);
      @(posedge clk) {idle_btn, cpu_idle, over_temp} <= 3'b011;
      #1 check("idle therm", {i_lmp, t_lmp}, 2'b11);
      // Each supply fault drops both supplies
      for (int f = 1; f < 3; f++) begin
         wr(REG_EVENT, 16'h003F);
         @(posedge clk) {supp_fault, main_fault} <= f[1:0];
         @(posedge clk) {supp_fault, main_fault} <= 2'b00;
         #1 check("fault off", {ac_on, m_en, s_en, r_lmp}, 0);
         rd(REG_EVENT, 16'h0010, "fault event");
         press(BTN_PON);
         wait_on(0, 1);
      end
      press(BTN_POFF);
      check("seq off", {dc_off, r_lmp, ac_on}, 3'b111);
      wait_on(0, 0);
      check("off", {ac_on, pfail}, 0);
      press(BTN_PON);
      wait_on(0, 1);
      wr(REG_EVENT, 16'h003F);
      press(BTN_MASTER);
      check("emergency", {ac_on, pfail, m_lmp, r_lmp}, 4'h4);
      rd(REG_EVENT, 16'h0001, "emerg event");
      @(posedge clk) pfail_ack <= 1'b1;
      @(posedge clk) pfail_ack <= 1'b0;
      #1 check("pfail ack", pfail, 0);
      summarize();
   end
endmodule : opp_panel_tb

`default_nettype wire
